// *** design/srstc_reset_ctrl.sv ***
// system reset controller: merges reset sources, records causes, soft reset, config reload
// assumes an AXI4-Lite master on i_clk_sys and asynchronous reset sources from pins/analog
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps

module srstc_reset_ctrl
    import srstc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_por_req,
    input wire logic i_bor_req,
    input wire logic i_external_clear_pin_n,
    input wire logic i_watchdog_timeout,
    input wire logic i_clk_stable,
    input wire logic i_cpu_sleep,
    input wire logic i_cpu_idle,
    input wire logic i_wait_sleep,
    input wire logic i_wait_idle,
    input wire logic i_irq_wake,
    input wire srstc_cfg_pair_t [`SRSTC_CFG_WORDS-1:0] i_fuse_cfg,
    output logic o_system_reset_out,
    output logic o_fetch_en,
    output logic [31:0] o_boot_vector,
    output logic o_wake_to_vector,
    output logic o_regulator_standby_sel,
    output logic [`SRSTC_CFG_WORDS*32-1:0] o_cfg_words
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction : strb_mask

    // op 0 plain write, 1 clear, 2 set, 3 invert of the bits written as one
    function automatic logic [31:0] apply_op(input logic [31:0] cur, input logic [31:0] d,
                                             input logic [31:0] m, input logic [1:0] op);
        logic [31:0] r;
        r = cur;
        unique case (op)
            2'h0: r = (cur & ~m) | (d & m);
            2'h1: r = cur & ~(d & m);
            2'h2: r = cur | (d & m);
            2'h3: r = cur ^ (d & m);
        endcase
        return r;
    endfunction : apply_op

    // ----------------------------------------------------------------
    // input synchronisers and clear pin filter
    // ----------------------------------------------------------------
    srstc_async_t sync1_reg;
    srstc_async_t sync2_reg;
    logic wdt_dly_reg;
    logic [7:0] clr_cnt_reg;
    logic clr_filt_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sync1_reg <= '{por: 1'b0, bor: 1'b0, clr_n: 1'b1, wdt: 1'b0, clk_ok: 1'b0};
            sync2_reg <= '{por: 1'b0, bor: 1'b0, clr_n: 1'b1, wdt: 1'b0, clk_ok: 1'b0};
            wdt_dly_reg <= 1'b0;
        end else begin
            sync1_reg <= '{por: i_por_req, bor: i_bor_req, clr_n: i_external_clear_pin_n,
                           wdt: i_watchdog_timeout, clk_ok: i_clk_stable};
            sync2_reg <= sync1_reg;
            wdt_dly_reg <= sync2_reg.wdt;
        end
    end

    // sampling on the system clock costs two cycles of latency against a true async assert
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            clr_cnt_reg <= 8'h00;
            clr_filt_reg <= 1'b0;
        end else if (sync2_reg.clr_n) begin
            clr_cnt_reg <= 8'h00;
            clr_filt_reg <= 1'b0;
        end else if (clr_cnt_reg == 8'(`SRSTC_CLR_MIN_CYC - 1)) begin
            clr_filt_reg <= 1'b1;
        end else begin
            clr_cnt_reg <= clr_cnt_reg + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic aw_full_reg;
    logic w_full_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_go;
    logic ar_hs;
    logic wr_cause;
    logic wr_soft;
    logic wr_key;
    logic [31:0] wmask;

    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ar_hs = i_s_axi_arvalid && arready_reg;
    assign wr_cause = wr_go && (aw_addr_reg[11:4] == 8'(`SRSTC_A_CAUSE >> 4));
    assign wr_soft = wr_go && (aw_addr_reg[11:4] == 8'(`SRSTC_A_SOFT >> 4));
    assign wr_key = wr_go && (aw_addr_reg == `SRSTC_A_KEY);
    assign wmask = strb_mask(w_strb_reg);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (i_s_axi_awvalid && awready_reg) begin
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_addr_reg <= i_s_axi_awaddr;
        end else begin
            if (wr_go) begin
                aw_full_reg <= 1'b0;
            end
            awready_reg <= !aw_full_reg && !bvalid_reg;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (i_s_axi_wvalid && wready_reg) begin
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
        end else begin
            if (wr_go) begin
                w_full_reg <= 1'b0;
            end
            wready_reg <= !w_full_reg && !bvalid_reg;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_cause || wr_soft || wr_key) ? 2'h0 : 2'h2;
        end else if (i_s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // unlock sequence and soft reset arm
    // ----------------------------------------------------------------
    srstc_lock_t lock_reg;
    logic arm_reg;
    logic sw_fire;
    srstc_state_t state_reg;
    logic start_rst;
    logic [31:0] soft_op;

    // companion ports read as zero; a read of any of them does not trigger
    assign sw_fire = ar_hs && arm_reg && (i_s_axi_araddr == `SRSTC_A_SOFT);
    assign soft_op = apply_op({31'h0, arm_reg}, w_data_reg, wmask, aw_addr_reg[3:2]);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (state_reg != ST_RUN)) begin
            lock_reg <= LK_LOCKED;
        end else if (wr_key) begin
            if (w_data_reg == `SRSTC_KEY1) begin
                lock_reg <= LK_KEY1;
            end else if (lock_reg == LK_KEY1 && w_data_reg == `SRSTC_KEY2) begin
                lock_reg <= LK_OPEN;
            end else begin
                lock_reg <= LK_LOCKED;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || start_rst || state_reg != ST_RUN) begin
            arm_reg <= 1'b0;
        end else if (wr_soft && lock_reg == LK_OPEN) begin
            if (aw_addr_reg[3:2] == 2'h0) begin
                arm_reg <= arm_reg | (w_data_reg[0] & w_strb_reg[0]);
            end else begin
                arm_reg <= soft_op[`SRSTC_SOFT_B_ARM];
            end
        end
    end

    // ----------------------------------------------------------------
    // reset events and cause flags
    // ----------------------------------------------------------------
    logic [`SRSTC_CAUSE_W-1:0] cause_reg;
    logic [`SRSTC_CAUSE_W-1:0] cause_next;
    logic wdt_evt;
    logic wdt_rst;
    logic wdt_wake;
    logic low_power;
    logic cmr_evt;
    logic mismatch;
    logic [31:0] cause_op;

    assign cause_op = apply_op({22'h0, cause_reg}, w_data_reg, wmask, aw_addr_reg[3:2]);
    assign low_power = i_cpu_sleep || i_cpu_idle;
    assign wdt_evt = sync2_reg.wdt && !wdt_dly_reg && state_reg == ST_RUN;
    assign wdt_rst = wdt_evt && !low_power;
    assign wdt_wake = wdt_evt && low_power;
    assign cmr_evt = mismatch && state_reg == ST_RUN;
    assign start_rst = sync2_reg.por || sync2_reg.bor || clr_filt_reg || wdt_rst || sw_fire
                       || cmr_evt;

    always_comb begin
        cause_next = cause_reg;
        if (wr_cause) begin
            cause_next = cause_op[`SRSTC_CAUSE_W-1:0] & `SRSTC_CAUSE_WMASK;
        end
        // hardware events are applied after the software write so a hardware set or clear wins over the write
        if (sync2_reg.por) begin
            cause_next = `SRSTC_CAUSE_POR_VAL;
        end else if (sync2_reg.bor) begin
            cause_next = (cause_next & `SRSTC_CAUSE_BOR_KEEP) | 10'h002;
        end else begin
            if (i_irq_wake) begin
                cause_next[`SRSTC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
            end
            if (i_wait_sleep || ((clr_filt_reg || wdt_evt) && i_cpu_sleep)) begin
                cause_next[`SRSTC_B_SLEEP] = 1'b1;
            end
            if (i_wait_idle || ((clr_filt_reg || wdt_evt) && i_cpu_idle)) begin
                cause_next[`SRSTC_B_IDLE] = 1'b1;
            end
            if (clr_filt_reg) begin
                cause_next[`SRSTC_B_PIN_RESET_FLAG] = 1'b1;
            end
            if (sw_fire) begin
                cause_next[`SRSTC_B_SWR] = 1'b1;
            end
            if (wdt_evt) begin
                cause_next[`SRSTC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            end
            if (cmr_evt) begin
                cause_next[`SRSTC_B_CMR] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cause_reg <= `SRSTC_CAUSE_POR_VAL;
        end else begin
            cause_reg <= cause_next;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
            if (i_s_axi_araddr == `SRSTC_A_CAUSE) begin
                rdata_reg <= {22'h0, cause_reg};
            end else if (i_s_axi_araddr == `SRSTC_A_SOFT) begin
                rdata_reg <= {31'h0, arm_reg};
            end else if (i_s_axi_araddr[11:5] != 7'(`SRSTC_A_CAUSE >> 5)
                         && i_s_axi_araddr != `SRSTC_A_KEY) begin
                rresp_reg <= 2'h2;
            end
        end else if (rvalid_reg) begin
            if (i_s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end else begin
            arready_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // sequencer and configuration words
    // ----------------------------------------------------------------
    logic [31:0] cfg_word_reg [`SRSTC_CFG_WORDS];
    logic [31:0] cfg_shadow_reg [`SRSTC_CFG_WORDS];
    logic [1:0] load_idx_reg;
    logic [3:0] dly_cnt_reg;
    logic sys_rst_reg;
    logic fetch_reg;

    always_comb begin
        mismatch = 1'b0;
        for (int i = 0; i < `SRSTC_CFG_WORDS; i++) begin
            mismatch = mismatch | (|(cfg_word_reg[i] ^ ~cfg_shadow_reg[i]));
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg <= ST_CLEAR;
            sys_rst_reg <= 1'b1;
            fetch_reg <= 1'b0;
            load_idx_reg <= 2'h0;
            dly_cnt_reg <= 4'h0;
        end else if (sync2_reg.por) begin
            state_reg <= ST_CLEAR;
            sys_rst_reg <= 1'b1;
            fetch_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (start_rst) begin
                        state_reg <= ST_LOAD;
                        sys_rst_reg <= 1'b1;
                        fetch_reg <= 1'b0;
                        load_idx_reg <= 2'h0;
                    end
                end
                ST_CLEAR: begin
                    state_reg <= ST_LOAD;
                    load_idx_reg <= 2'h0;
                end
                ST_LOAD: begin
                    load_idx_reg <= load_idx_reg + 2'h1;
                    if (load_idx_reg == 2'(`SRSTC_CFG_WORDS - 1)) begin
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // power-on, brown-out and clear pin sources that are still asserted keep the system in reset
                    if (!sync2_reg.bor && !clr_filt_reg && sync2_reg.clk_ok) begin
                        state_reg <= ST_DELAY;
                        sys_rst_reg <= 1'b0;
                        dly_cnt_reg <= 4'h1;
                    end
                end
                ST_DELAY: begin
                    if (start_rst) begin
                        state_reg <= ST_LOAD;
                        sys_rst_reg <= 1'b1;
                        load_idx_reg <= 2'h0;
                    end else if (dly_cnt_reg == `SRSTC_FETCH_DLY_CYC) begin
                        state_reg <= ST_RUN;
                        fetch_reg <= 1'b1;
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || state_reg == ST_CLEAR) begin
            for (int i = 0; i < `SRSTC_CFG_WORDS; i++) begin
                cfg_word_reg[i] <= 32'h00000000;
                cfg_shadow_reg[i] <= 32'hFFFFFFFF;
            end
        end else if (state_reg == ST_LOAD) begin
            cfg_word_reg[load_idx_reg] <= i_fuse_cfg[load_idx_reg].word;
            cfg_shadow_reg[load_idx_reg] <= i_fuse_cfg[load_idx_reg].shadow;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_wake_to_vector <= 1'b0;
            o_boot_vector <= `SRSTC_BOOT_VEC;
        end else begin
            o_wake_to_vector <= wdt_wake;
            o_boot_vector <= `SRSTC_BOOT_VEC;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_s_axi_awready = awready_reg;
    assign o_s_axi_wready = wready_reg;
    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp = bresp_reg;
    assign o_s_axi_arready = arready_reg;
    assign o_s_axi_rvalid = rvalid_reg;
    assign o_s_axi_rresp = rresp_reg;
    assign o_s_axi_rdata = rdata_reg;
    assign o_system_reset_out = sys_rst_reg;
    assign o_fetch_en = fetch_reg;
    assign o_regulator_standby_sel = cause_reg[`SRSTC_B_REGULATOR_STANDBY_SEL];

    for (genvar g = 0; g < `SRSTC_CFG_WORDS; g++) begin : g_cfg
        assign o_cfg_words[g*32 +: 32] = cfg_word_reg[g];
    end

endmodule : srstc_reset_ctrl

// *** design/srstc_map.svh ***
// register map, field positions, reset values and timing counts of the reset controller
// assumes a 12-bit byte address on the register bus and a 125 MHz system clock
`ifndef SRSTC_MAP_SVH
`define SRSTC_MAP_SVH

// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define SRSTC_A_CAUSE 12'h600
`define SRSTC_A_CAUSE_CLR 12'h604
`define SRSTC_A_CAUSE_SET 12'h608
`define SRSTC_A_CAUSE_INV 12'h60C
`define SRSTC_A_SOFT 12'h610
`define SRSTC_A_SOFT_CLR 12'h614
`define SRSTC_A_SOFT_SET 12'h618
`define SRSTC_A_SOFT_INV 12'h61C
`define SRSTC_A_KEY 12'h630

// ----------------------------------------------------------------
// cause register fields
// ----------------------------------------------------------------
`define SRSTC_B_POR 0
`define SRSTC_B_BOR 1
`define SRSTC_B_IDLE 2
`define SRSTC_B_SLEEP 3
`define SRSTC_B_WATCHDOG_TIMEOUT_FLAG 4
`define SRSTC_B_SWR 6
`define SRSTC_B_PIN_RESET_FLAG 7
`define SRSTC_B_REGULATOR_STANDBY_SEL 8
`define SRSTC_B_CMR 9
`define SRSTC_CAUSE_W 10
`define SRSTC_CAUSE_WMASK 10'h3DF
`define SRSTC_CAUSE_POR_VAL 10'h003
`define SRSTC_CAUSE_BOR_KEEP 10'h101
`define SRSTC_SOFT_B_ARM 0

// ----------------------------------------------------------------
// keys, vector, timing
// ----------------------------------------------------------------
`define SRSTC_KEY1 32'hAA996655
`define SRSTC_KEY2 32'h556699AA
`define SRSTC_BOOT_VEC 32'hBFC00000
`define SRSTC_CFG_WORDS 4
`define SRSTC_FETCH_DLY_CYC 4'h8
`define SRSTC_CLK_MHZ 125
`define SRSTC_CLR_MIN_NS 200
`define SRSTC_CLR_MIN_CYC ((`SRSTC_CLR_MIN_NS * `SRSTC_CLK_MHZ + 999) / 1000)

`endif

// *** design/srstc_pkg.sv ***
// types shared by the reset controller
// assumes srstc_map.svh is on the include path
`include "srstc_map.svh"

package srstc_pkg;

    typedef enum logic [2:0] {ST_RUN, ST_CLEAR, ST_LOAD, ST_HOLD, ST_DELAY} srstc_state_t;

    typedef enum logic [1:0] {LK_LOCKED, LK_KEY1, LK_OPEN} srstc_lock_t;

    // one configuration word with its complementary shadow copy
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] shadow;
    } srstc_cfg_pair_t;

    // synchronised asynchronous inputs
    typedef struct packed {
        logic por;
        logic bor;
        logic clr_n;
        logic wdt;
        logic clk_ok;
    } srstc_async_t;

endpackage : srstc_pkg

// *** tb/srstc_reset_monitor.sv ***
// port assertions of the reset controller
// assumes a bind from the bench top file
`timescale 1ns/10ps

module srstc_reset_monitor (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic o_s_axi_rvalid,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic i_cpu_sleep,
    input wire logic i_cpu_idle,
    input wire logic o_system_reset_out,
    input wire logic o_fetch_en,
    input wire logic [31:0] o_boot_vector,
    input wire logic o_wake_to_vector
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    fetch_delay_a: assert property ($fell(o_system_reset_out) |-> !o_fetch_en [*8] ##1 o_fetch_en)
        else $error("fetch not enabled 8 cycles after release");
    fetch_off_a: assert property (o_system_reset_out |=> !o_fetch_en)
        else $error("fetch enabled during reset");
    boot_vec_a: assert property (o_boot_vector == 32'hBFC00000)
        else $error("boot vector wrong");
    wake_no_rst_a: assert property (o_wake_to_vector |-> !o_system_reset_out)
        else $error("wake from sleep caused a reset");
    wake_pulse_a: assert property (o_wake_to_vector |=> !o_wake_to_vector)
        else $error("wake pulse longer than one cycle");
    wake_mode_a: assert property (o_wake_to_vector |-> $past(i_cpu_sleep | i_cpu_idle))
        else $error("wake pulse outside sleep or idle");
    soft_trig_a: assert property ($rose(o_s_axi_rvalid) && $past(i_s_axi_araddr) == 12'h610
        && o_s_axi_rdata[0] |-> o_system_reset_out)
        else $error("armed read did not reset");
    flag_norst_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_awaddr[11:4] == 8'h60
        && !o_system_reset_out |=> !o_system_reset_out [*4])
        else $error("flag write started a reset");

    cover property ($rose(o_system_reset_out));
    cover property (o_wake_to_vector);
    cover property ($rose(o_fetch_en));
endmodule : srstc_reset_monitor

// *** tb/srstc_core_model.sv ***
// core model: sleep via wait instruction, wake interrupt, fuse source
// assumes one-cycle commands from the bench on the system clock
`timescale 1ns/10ps

module srstc_core_model
    import srstc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sleep_cmd,
    input wire logic i_wake_cmd,
    input wire logic i_bad_fuse,
    output logic o_cpu_sleep,
    output logic o_cpu_idle,
    output logic o_wait_sleep,
    output logic o_wait_idle,
    output logic o_irq_wake,
    output srstc_cfg_pair_t [`SRSTC_CFG_WORDS-1:0] o_fuse_cfg
);
    // idle mode is not modelled; sleep covers the same flag path
    assign o_cpu_idle = 1'h0;
    assign o_wait_idle = 1'h0;

    always_ff @(posedge i_clk_sys) begin
        o_wait_sleep <= i_sleep_cmd & ~i_sys_rst;
        o_irq_wake <= i_wake_cmd & o_cpu_sleep;
        if (i_sys_rst || i_wake_cmd) begin
            o_cpu_sleep <= 1'h0;
        end else if (i_sleep_cmd) begin
            o_cpu_sleep <= 1'h1;
        end
    end

    always_comb begin
        for (int k = 0; k < `SRSTC_CFG_WORDS; k++) begin
            o_fuse_cfg[k].word = 32'h5A0F0000 | 32'(k);
            o_fuse_cfg[k].shadow = ~o_fuse_cfg[k].word ^ {31'h0, i_bad_fuse && k == 0};
        end
    end
endmodule : srstc_core_model

// *** tb/srstc_reset_ctrl_bench.sv ***
// self-checking bench of the reset controller
// assumes the design, core model and monitor files compiled before it
`timescale 1ns/10ps

module srstc_reset_ctrl_bench
    import srstc_pkg::*;
;
    logic i_clk_sys = 1'h0, i_sys_rst = 1'h1;
    logic [11:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
    logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, o_boot_vector, rv;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0;
    logic i_s_axi_arvalid = '0, i_s_axi_rready = '0, i_por_req = '0, i_clk_stable = '1;
    logic [5:0] stim = 6'h01; // clear pin, watchdog, sleep, wake, brown-out, bad fuse
    wire i_external_clear_pin_n = stim[0], i_watchdog_timeout = stim[1], sleep_cmd = stim[2];
    wire wake_cmd = stim[3], i_bor_req = stim[4], bad_fuse = stim[5];
    logic i_cpu_sleep, i_cpu_idle, i_wait_sleep, i_wait_idle, i_irq_wake;
    srstc_cfg_pair_t [`SRSTC_CFG_WORDS-1:0] i_fuse_cfg;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
    logic o_system_reset_out, o_fetch_en, o_wake_to_vector, o_regulator_standby_sel;
    logic [`SRSTC_CFG_WORDS*32-1:0] o_cfg_words;
    int error_cnt = 0, checked = 0, cyc = 0;

    srstc_reset_ctrl DUT (.*);
    srstc_core_model u_core (.i_clk_sys, .i_sys_rst, .i_sleep_cmd(sleep_cmd),
        .i_wake_cmd(wake_cmd), .i_bad_fuse(bad_fuse), .o_cpu_sleep(i_cpu_sleep),
        .o_cpu_idle(i_cpu_idle), .o_wait_sleep(i_wait_sleep), .o_wait_idle(i_wait_idle),
        .o_irq_wake(i_irq_wake), .o_fuse_cfg(i_fuse_cfg));

    always #4 i_clk_sys = ~i_clk_sys;

    // ----
    // bus and check tasks
    // ----
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid <= 1'h1;
        do begin
            @(posedge i_clk_sys);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
        end while (i_s_axi_awvalid && !o_s_axi_awready || i_s_axi_wvalid && !o_s_axi_wready);
        i_s_axi_bready <= 1'h1;
        do @(posedge i_clk_sys); while (!o_s_axi_bvalid);
        i_s_axi_bready <= 1'h0;
    endtask : wr

    task rd(input logic [11:0] a);
        @(posedge i_clk_sys);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'h1;
        do @(posedge i_clk_sys); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'h0;
        i_s_axi_rready <= 1'h1;
        do @(posedge i_clk_sys); while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'h0;
        rv = o_s_axi_rdata;
        rs = o_s_axi_rresp;
    endtask : rd

    task boot(input string n);
        repeat (300) if (!o_system_reset_out) @(posedge i_clk_sys);
        chk(n, o_system_reset_out, 32'h1);
        repeat (2) @(posedge i_clk_sys);
        repeat (300) if (!o_fetch_en) @(posedge i_clk_sys);
        chk("fetch", o_fetch_en, 32'h1);
    endtask : boot

    task cause(input logic [31:0] e);
        rd(`SRSTC_A_CAUSE);
        chk("cause", rv, e);
        wr(`SRSTC_A_CAUSE_CLR, 32'h3FF);
    endtask : cause

    task pulse(input int w, input logic v, input int n);
        @(posedge i_clk_sys);
        stim[w] <= v;
        repeat (n) @(posedge i_clk_sys);
        stim[w] <= ~v;
    endtask : pulse

    // ----
    // scenarios
    // ----
    task t_por;
        boot("por");
        chk("cfg0", o_cfg_words[31:0], 32'h5A0F0000);
        cause(32'h3);
        $display("por done");
    endtask : t_por

    task t_flags;
        wr(`SRSTC_A_CAUSE_SET, 32'h2C0);
        rd(`SRSTC_A_CAUSE);
        chk("set", rv, 32'h2C0);
        chk("noreset", o_system_reset_out, 32'h0);
        wr(`SRSTC_A_CAUSE_INV, 32'h0C0);
        cause(32'h200);
        rd(12'h700);
        chk("unmapped", rs, 32'h2);
        $display("flags done");
    endtask : t_flags

    task t_soft;
        wr(`SRSTC_A_SOFT_SET, 32'h1);
        rd(`SRSTC_A_SOFT);
        chk("locked", rv, 32'h0);
        wr(`SRSTC_A_KEY, `SRSTC_KEY1);
        wr(`SRSTC_A_KEY, `SRSTC_KEY2);
        wr(`SRSTC_A_SOFT, 32'h0);
        rd(`SRSTC_A_SOFT);
        chk("zero", rv | {31'h0, o_system_reset_out}, 32'h0);
        wr(`SRSTC_A_SOFT, 32'h1);
        rd(`SRSTC_A_SOFT);
        chk("trigger", o_system_reset_out, 32'h1);
        boot("swr");
        cause(32'h40);
        rd(`SRSTC_A_SOFT);
        chk("disarmed", rv, 32'h0);
        $display("soft done");
    endtask : t_soft

    task t_pin;
        pulse(0, 1'h0, 10);
        repeat (40) @(posedge i_clk_sys);
        chk("filtered", o_system_reset_out, 32'h0);
        pulse(0, 1'h0, 40);
        boot("pin");
        cause(32'h80);
        $display("pin done");
    endtask : t_pin

    task t_wdt;
        pulse(1, 1'h1, 5);
        boot("wdt");
        cause(32'h10);
        pulse(2, 1'h1, 1);
        pulse(1, 1'h1, 1);
        repeat (20) if (!o_wake_to_vector) @(posedge i_clk_sys);
        chk("wake", o_wake_to_vector, 32'h1);
        rd(`SRSTC_A_CAUSE);
        chk("sleepwdt", rv | {31'h0, o_system_reset_out}, 32'h18);
        pulse(3, 1'h1, 1);
        repeat (4) @(posedge i_clk_sys);
        cause(32'h8);
        $display("wdt done");
    endtask : t_wdt

    task t_bor_cmr;
        wr(`SRSTC_A_CAUSE_SET, 32'h1C0);
        pulse(4, 1'h1, 5);
        boot("bor");
        cause(32'h102);
        stim[5] <= 1'h1;
        pulse(1, 1'h1, 5);
        repeat (300) if (!o_fetch_en) @(posedge i_clk_sys);
        stim[5] <= 1'h0;
        boot("cmr");
        cause(32'h210);
        chk("cfg3", o_cfg_words[127:96], 32'h5A0F0003);
        $display("bor cmr done");
    endtask : t_bor_cmr

    task test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'h0;
        t_por();
        t_flags();
        t_soft();
        t_pin();
        t_wdt();
        t_bor_cmr();
        test_done();
    end
endmodule : srstc_reset_ctrl_bench

bind srstc_reset_ctrl srstc_reset_monitor u_mon (.i_clk_sys, .i_sys_rst, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_araddr, .o_s_axi_rvalid, .o_s_axi_rdata,
    .i_cpu_sleep, .i_cpu_idle, .o_system_reset_out, .o_fetch_en, .o_boot_vector,
    .o_wake_to_vector);
